// File: verilog/rp_defs.svh
// Constants of the ring PHY clock and status block.
// Assumes hclk runs at 200 MHz; included by its bare name.
`ifndef RP_DEFS_SVH
`define RP_DEFS_SVH

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define RP_OFF_CTRL     12'h000
`define RP_OFF_STATUS   12'h004
`define RP_OFF_INT_STAT 12'h008
`define RP_OFF_INT_EN   12'h00c
`define RP_OFF_INT_CLR  12'h010
`define RP_CTRL_ACQ     0
`define RP_ST_RATE      0
`define RP_ST_READY_N   1
`define RP_ST_SPEED     2
`define RP_ST_PRESENT   3
`define RP_IRQ_RATE     0
`define RP_IRQ_LOST     1
`define RP_IRQ_READY    2
`define RP_INT_EN_RST   3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define RP_CLK_PS       5000
`define RP_CLK_MHZ      200
`define RP_FAST_MHZ     32
`define RP_SLOW_MHZ     8
`define RP_INC(f)       32'((64'(f) << 32) / 64'(`RP_CLK_MHZ))
`define RP_HBIT16_PS    31250
`define RP_HBIT4_PS     125000
`define RP_GAP_MIN(h)   8'(((h) / `RP_CLK_PS) - 1)
`define RP_GAP_MAX(h)   8'(((3 * (h) + `RP_CLK_PS - 1) / `RP_CLK_PS) + 1)
`define RP_LOSS_NS      1000
`define RP_LOSS_CYC     8'((`RP_LOSS_NS * 1000) / `RP_CLK_PS)
`define RP_REINIT_NS    2000
`define RP_REINIT_CYC   9'((`RP_REINIT_NS * 1000) / `RP_CLK_PS)
`define RP_GOOD_RUN     4'h8

`endif

// File: verilog/rp_pkg.sv
// Types of the ring PHY clock and status block.
// Assumes nothing of its surroundings.
package rp_pkg;

  // Recovery PLL state, Gray coded along reinit, hunt, locked
  typedef enum logic [1:0] {
    RP_REINIT = 2'h0,
    RP_HUNT   = 2'h1,
    RP_LOCKED = 2'h3
  } rp_pll_state_t;

endpackage : rp_pkg

// File: verilog/rp_nco_if.sv
// Connection between the control logic and one phase accumulator.
// Assumes both ends run on hclk.
`timescale 1ns/1ps

interface rp_nco_if;
  logic [31:0] inc;
  logic        sync;
  logic        clk_out;
  logic        rise;

  modport ctl (output inc, output sync, input clk_out, input rise);
  modport nco (input inc, input sync, output clk_out, output rise);
endinterface : rp_nco_if

// File: verilog/rp_nco.sv
// Phase accumulator clock synthesiser.
// Assumes a single hclk domain; sync restarts the phase at zero.
`timescale 1ns/1ps

module rp_nco (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control side
  rp_nco_if.nco    port
);

  logic [31:0] acc;

  // Output is the accumulator top bit; edges jitter by one hclk period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc <= 32'h0;
    end else if (port.sync) begin
      acc <= 32'h0;
    end else begin
      acc <= acc + port.inc;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port.clk_out <= 1'b0;
      port.rise    <= 1'b0;
    end else begin
      port.clk_out <= acc[31];
      port.rise    <= acc[31] & ~port.clk_out;
    end
  end

endmodule : rp_nco

// File: verilog/rp_phy_clock_status.sv
// Ring PHY clock generation, data recovery and receive status.
// Assumes pins arrive asynchronously and an AHB-Lite master on hclk.
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "rp_defs.svh"

module rp_phy_clock_status (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Interrupt
  output logic             irq,
  // Pins
  input  wire logic        oscillator_input,
  input  wire logic        osc_divide_select,
  input  wire logic        ring_speed_select,
  input  wire logic        freq_acquire_request,
  input  wire logic        phy_power_down_n,
  input  wire logic        wrap_n,
  input  wire logic        rcv_line,
  input  wire logic        drv_line,
  output logic             divided_clock_out,
  output logic             reference_clock_out,
  output logic             reference_clock_oe_n,
  output logic             recovered_clock_out,
  output logic             recovered_clock_oe_n,
  output logic             recovered_data_out,
  output logic             recovered_data_oe_n,
  output logic             rate_error_flag,
  output logic             rate_error_oe_n,
  output logic             pll_ready_n,
  output logic             pll_ready_oe_n
);

  localparam int NPIN = 8;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_f;

  assign pin_raw = {drv_line, rcv_line, wrap_n, phy_power_down_n,
                    freq_acquire_request, ring_speed_select,
                    osc_divide_select, oscillator_input};

  // A change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
          pin_f[gi]  <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_f[gi] <= pin_s3[gi];
          end
        end
      end
    end
  endgenerate

  logic osc_f;
  logic div8_f;
  logic speed16_f;
  logic acq_f;
  logic pwr_on_f;
  logic wrap_f;
  logic line_f;

  assign osc_f     = pin_f[0];
  assign div8_f    = pin_f[1];
  assign speed16_f = pin_f[2];
  assign acq_f     = pin_f[3];
  assign pwr_on_f  = pin_f[4];
  assign wrap_f    = ~pin_f[5];
  // In wrap mode the transmit pair is watched instead of the receive pair
  assign line_f    = wrap_f ? pin_f[7] : pin_f[6];

  // ----------------------------------------
  // Oscillator divider
  // ----------------------------------------
  // Oscillator must stay at or below a quarter of hclk to be seen by the filter
  logic       osc_d;
  logic [1:0] div_cnt;
  logic [1:0] div_last;

  assign div_last = div8_f ? 2'h3 : 2'h1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_d             <= 1'b0;
      div_cnt           <= 2'h0;
      divided_clock_out <= 1'b0;
    end else begin
      osc_d <= osc_f;
      if (osc_f & ~osc_d) begin
        if (div_cnt >= div_last) begin
          div_cnt           <= 2'h0;
          divided_clock_out <= ~divided_clock_out;
        end else begin
          div_cnt <= div_cnt + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Transition rate monitor
  // ----------------------------------------
  logic       speed_act;
  logic       line_d;
  logic       edge_seen;
  logic [7:0] gap;
  logic [7:0] gap_min;
  logic [7:0] gap_max;
  logic       present;
  logic       rate_err;
  logic [3:0] good_run;

  assign edge_seen = line_f ^ line_d;
  assign gap_min   = speed_act ? `RP_GAP_MIN(`RP_HBIT16_PS) : `RP_GAP_MIN(`RP_HBIT4_PS);
  assign gap_max   = speed_act ? `RP_GAP_MAX(`RP_HBIT16_PS) : `RP_GAP_MAX(`RP_HBIT4_PS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_d <= 1'b0;
      gap    <= 8'h0;
    end else begin
      line_d <= line_f;
      if (edge_seen) begin
        gap <= 8'h0;
      end else if (gap != 8'hff) begin
        gap <= gap + 8'h1;
      end
    end
  end

  // Signal counts as present while transitions keep coming
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      present <= 1'b0;
    end else if (edge_seen) begin
      present <= 1'b1;
    end else if (gap >= `RP_LOSS_CYC) begin
      present <= 1'b0;
    end
  end

  // One bad gap raises the flag; a run of good gaps clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_err <= 1'b0;
      good_run <= 4'h0;
    end else if (!present) begin
      rate_err <= 1'b0;
      good_run <= 4'h0;
    end else if (edge_seen && gap != 8'hff) begin
      if (gap < gap_min || gap > gap_max) begin
        rate_err <= 1'b1;
        good_run <= 4'h0;
      end else if (good_run == `RP_GOOD_RUN) begin
        rate_err <= 1'b0;
      end else begin
        good_run <= good_run + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Recovery PLL control
  // ----------------------------------------
  rp_pkg::rp_pll_state_t state;
  rp_pkg::rp_pll_state_t next_state;
  logic       acq_d;
  logic       acq_req;
  logic       soft_acq;
  logic [8:0] reinit_cnt;

  assign acq_req = (acq_f & ~acq_d) | soft_acq | (speed16_f != speed_act) | ~pwr_on_f;

  always_comb begin
    next_state = state;
    case (state)
      rp_pkg::RP_REINIT: begin
        if (reinit_cnt == `RP_REINIT_CYC) begin
          next_state = rp_pkg::RP_HUNT;
        end
      end
      rp_pkg::RP_HUNT: begin
        if (present && !rate_err) begin
          next_state = rp_pkg::RP_LOCKED;
        end
      end
      rp_pkg::RP_LOCKED: begin
        if (!present || rate_err) begin
          next_state = rp_pkg::RP_HUNT;
        end
      end
      default: begin
        next_state = rp_pkg::RP_REINIT;
      end
    endcase
    if (acq_req) begin
      next_state = rp_pkg::RP_REINIT;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= rp_pkg::RP_REINIT;
      acq_d <= 1'b0;
    end else begin
      state <= next_state;
      acq_d <= acq_f;
    end
  end

  // Speed is taken only at the start of a reinit, on acq_req
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reinit_cnt <= 9'h0;
      speed_act  <= 1'b0;
    end else if (state != rp_pkg::RP_REINIT || acq_req) begin
      reinit_cnt <= 9'h0;
      if (acq_req) begin
        speed_act <= speed16_f;
      end
    end else if (reinit_cnt != `RP_REINIT_CYC) begin
      reinit_cnt <= reinit_cnt + 9'h1;
    end
  end

  // ----------------------------------------
  // Clock synthesis and data recovery
  // ----------------------------------------
  rp_nco_if ref_if ();
  rp_nco_if rec_if ();

  assign ref_if.inc  = speed_act ? `RP_INC(`RP_FAST_MHZ) : `RP_INC(`RP_SLOW_MHZ);
  assign ref_if.sync = 1'b0;
  assign rec_if.inc  = ref_if.inc;
  // Line edges restart recovered phase so its rise lands mid half-bit
  assign rec_if.sync = edge_seen;

  rp_nco u_ref (
    .hclk    (hclk),
    .hresetn (hresetn),
    .port    (ref_if.nco)
  );

  rp_nco u_rec (
    .hclk    (hclk),
    .hresetn (hresetn),
    .port    (rec_if.nco)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reference_clock_out <= 1'b0;
      recovered_clock_out <= 1'b0;
      recovered_data_out  <= 1'b0;
      rate_error_flag     <= 1'b0;
      pll_ready_n         <= 1'b1;
    end else begin
      reference_clock_out <= ref_if.clk_out;
      recovered_clock_out <= rec_if.clk_out;
      if (rec_if.rise) begin
        recovered_data_out <= line_f;
      end
      rate_error_flag <= rate_err;
      // Invalid data or no signal leaves ready high
      pll_ready_n <= (next_state != rp_pkg::RP_LOCKED);
    end
  end

  // ----------------------------------------
  // Power down
  // ----------------------------------------
  logic phy_oe_n;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_oe_n <= 1'b1;
    end else begin
      phy_oe_n <= ~pwr_on_f;
    end
  end

  assign reference_clock_oe_n = phy_oe_n;
  assign recovered_clock_oe_n = phy_oe_n;
  assign recovered_data_oe_n  = phy_oe_n;
  assign rate_error_oe_n      = phy_oe_n;
  assign pll_ready_oe_n       = phy_oe_n;

  // ----------------------------------------
  // AHB-Lite registers
  // ----------------------------------------
  function automatic logic [2:0] reg_index(input logic [31:0] a);
    case (a[11:0])
      `RP_OFF_CTRL:     reg_index = 3'h1;
      `RP_OFF_STATUS:   reg_index = 3'h2;
      `RP_OFF_INT_STAT: reg_index = 3'h3;
      `RP_OFF_INT_EN:   reg_index = 3'h4;
      `RP_OFF_INT_CLR:  reg_index = 3'h5;
      default:          reg_index = 3'h0;
    endcase
  endfunction : reg_index

  logic       addr_ok;
  logic       wr_pend;
  logic [2:0] wr_idx;
  logic [2:0] int_stat;
  logic [2:0] int_en;
  logic [2:0] int_clr;
  logic [2:0] events;
  logic       rate_d;
  logic       ready_n_d;

  assign addr_ok = hsel & htrans[1] & hready;
  assign int_clr = (wr_pend && wr_idx == 3'h5) ? hwdata[2:0] : 3'h0;

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_idx    <= 3'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= addr_ok & hwrite;
      wr_idx    <= reg_index(haddr);
    end
  end

  // Acquire bit pulses for one cycle; it never reads back as one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_acq <= 1'b0;
      int_en   <= `RP_INT_EN_RST;
    end else begin
      soft_acq <= wr_pend && wr_idx == 3'h1 && hwdata[`RP_CTRL_ACQ];
      if (wr_pend && wr_idx == 3'h4) begin
        int_en <= hwdata[2:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      hrdata <= 32'h0;
      case (reg_index(haddr))
        3'h2: begin
          hrdata[`RP_ST_RATE]    <= rate_err;
          hrdata[`RP_ST_READY_N] <= pll_ready_n;
          hrdata[`RP_ST_SPEED]   <= speed_act;
          hrdata[`RP_ST_PRESENT] <= present;
        end
        3'h3: hrdata[2:0] <= int_stat;
        3'h4: hrdata[2:0] <= int_en;
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign events[`RP_IRQ_RATE]  = rate_err & ~rate_d;
  assign events[`RP_IRQ_LOST]  = pll_ready_n & ~ready_n_d;
  assign events[`RP_IRQ_READY] = ~pll_ready_n & ready_n_d;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_d    <= 1'b0;
      ready_n_d <= 1'b1;
      int_stat  <= 3'h0;
      irq       <= 1'b0;
    end else begin
      rate_d    <= rate_err;
      ready_n_d <= pll_ready_n;
      int_stat  <= (int_stat & ~int_clr) | events;
      irq       <= |(int_stat & int_en);
    end
  end

endmodule : rp_phy_clock_status

// File: bench/rp_line_model.sv
// Far side: one ring line, or the board oscillator, as a toggling level.
// Assumes hclk timing; a gap of zero holds the line still (no signal).
`timescale 1ns/1ps

module rp_line_model (
  // Clock
  input  wire logic       hclk,
  // Cycles between transitions
  input  wire logic [7:0] gap,
  // Line
  output logic            line
);
  logic [7:0] cnt = 8'h0;

  initial line = 1'b0;

  always @(posedge hclk) begin
    if (gap == 8'h0) begin
      cnt <= 8'h0;
    end else if (cnt + 8'h1 >= gap) begin
      cnt  <= 8'h0;
      line <= ~line;
    end else begin
      cnt <= cnt + 8'h1;
    end
  end
endmodule : rp_line_model

// File: bench/rp_props.sv
// Assertions on the ports of the ring PHY clock and status block.
// Assumes one hclk domain and an oscillator of hclk / 8; bound below.
`timescale 1ns/1ps

module rp_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins in
  input wire logic oscillator_input,
  input wire logic osc_divide_select,
  input wire logic ring_speed_select,
  input wire logic freq_acquire_request,
  input wire logic phy_power_down_n,
  input wire logic rcv_line,
  input wire logic drv_line,
  input wire logic wrap_n,
  // Pins out
  input wire logic divided_clock_out,
  input wire logic reference_clock_out,
  input wire logic reference_clock_oe_n,
  input wire logic recovered_data_out,
  input wire logic rate_error_flag,
  input wire logic pll_ready_n,
  input wire logic pll_ready_oe_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ------
  // Helper counters
  // ------
  logic       div_q, sel_q, spd_q, ref_q, acq_q, rx_q, tx_q, dv_ok, ref_ok;
  logic [5:0] dv_n, per_n;
  logic [9:0] acq_n, age_n, quiet_n;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {div_q, sel_q, spd_q, ref_q, acq_q, rx_q, tx_q} <= 7'h0;
    end else begin
      {div_q, sel_q, spd_q, ref_q, acq_q, rx_q, tx_q} <= {divided_clock_out, osc_divide_select,
        ring_speed_select, reference_clock_out, freq_acquire_request, rcv_line, drv_line};
    end
  end

  // Periods are only trusted once a full one has passed under a steady setting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {dv_n, per_n, dv_ok, ref_ok} <= 14'h0;
      {acq_n, age_n, quiet_n}      <= 30'h0;
    end else begin
      dv_n    <= (divided_clock_out != div_q) ? 6'h0 : dv_n + {5'h0, dv_n != 6'h3f};
      dv_ok   <= (osc_divide_select == sel_q) && (dv_ok || divided_clock_out != div_q);
      per_n   <= (reference_clock_out && !ref_q) ? 6'h0 : per_n + {5'h0, per_n != 6'h3f};
      ref_ok  <= age_n[9] && (ref_ok || (reference_clock_out && !ref_q));
      age_n   <= (pll_ready_n || ring_speed_select != spd_q) ? 10'h0 : age_n + {9'h0, !age_n[9]};
      quiet_n <= (rcv_line != rx_q || drv_line != tx_q) ? 10'h0 : quiet_n + {9'h0, quiet_n != 10'h3ff};
      acq_n   <= (freq_acquire_request && !acq_q) ? 10'h1 : acq_n + {9'h0, acq_n != 10'h0 && acq_n != 10'h3ff};
    end
  end

  sequence acq_edge_s;
    $rose(freq_acquire_request);
  endsequence
  sequence pd_held_s;
    !phy_power_down_n [*8];
  endsequence

  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  oe_same_a: assert property (reference_clock_oe_n == pll_ready_oe_n)
    else $error("output enables differ");
  pd_float_a: assert property (pd_held_s |-> reference_clock_oe_n && pll_ready_oe_n)
    else $error("outputs driven in power down");
  acq_drop_a: assert property (acq_edge_s |-> ##[1:8] pll_ready_n)
    else $error("ready kept after acquire");
  reinit_hold_a: assert property (acq_n > 10'h00a && acq_n < 10'h190 |-> pll_ready_n)
    else $error("ready during reinit");
  speed_reinit_a: assert property ($changed(ring_speed_select) |-> ##[1:8] pll_ready_n)
    else $error("speed change without reinit");
  quiet_lost_a: assert property (quiet_n > 10'h0e6 |-> pll_ready_n && !rate_error_flag)
    else $error("no signal but ready or rate error");
  // Only long gaps give the recovered phase time to settle on the new level
  rec_data_a: assert property (quiet_n > 10'h018 && !pll_ready_n && wrap_n |-> recovered_data_out == rx_q)
    else $error("recovered data differs from line");
  div_rate_a: assert property (divided_clock_out != div_q && dv_ok |->
    (osc_divide_select ? dv_n inside {[30:33]} : dv_n inside {[14:17]})) else $error("divided clock rate");
  ref_rate_a: assert property (reference_clock_out && !ref_q && ref_ok |->
    (ring_speed_select ? per_n inside {[5:6]} : per_n inside {[23:25]})) else $error("reference clock rate");
endmodule : rp_props

bind rp_phy_clock_status rp_props rp_props_inst (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .oscillator_input(oscillator_input), .osc_divide_select(osc_divide_select),
  .ring_speed_select(ring_speed_select), .freq_acquire_request(freq_acquire_request),
  .phy_power_down_n(phy_power_down_n), .rcv_line(rcv_line), .drv_line(drv_line), .wrap_n(wrap_n),
  .recovered_data_out(recovered_data_out),
  .divided_clock_out(divided_clock_out), .reference_clock_out(reference_clock_out),
  .reference_clock_oe_n(reference_clock_oe_n), .rate_error_flag(rate_error_flag),
  .pll_ready_n(pll_ready_n), .pll_ready_oe_n(pll_ready_oe_n)
);

// File: bench/ring_phy_clock_status_bench.sv
// Self-checking bench of the ring PHY clock and status block.
// Assumes rp_line_model on the far side and rp_props bound to the design.
`timescale 1ns/1ps
`include "rp_defs.svh"

module ring_phy_clock_status_bench;
  // ------
  // Signals and instances
  // ------
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h34ac;
  logic [1:0]  htrans = 2'h0;
  logic        osc_divide_select = 1'b0, ring_speed_select = 1'b1, freq_acquire_request = 1'b0;
  logic        phy_power_down_n = 1'b1, wrap_n = 1'b1, bad = 1'b0, mute_rx = 1'b0, mute_tx = 1'b0;
  logic [7:0]  gap = 8'h8;
  logic        hreadyout, irq, oscillator_input, rcv_line, drv_line, rate_error_flag, pll_ready_n, pll_ready_oe_n;
  logic        divided_clock_out, recovered_clock_out, recovered_data_out;
  logic [31:0] hrdata, q_exp[$], q_msk[$];
  int          n_fail = 0, compares = 0, cyc = 0;

  rp_phy_clock_status rp_phy_clock_status_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .irq(irq), .oscillator_input(oscillator_input), .osc_divide_select(osc_divide_select),
    .ring_speed_select(ring_speed_select), .freq_acquire_request(freq_acquire_request),
    .phy_power_down_n(phy_power_down_n), .wrap_n(wrap_n), .rcv_line(rcv_line), .drv_line(drv_line),
    .divided_clock_out(divided_clock_out), .reference_clock_out(), .reference_clock_oe_n(),
    .recovered_clock_out(recovered_clock_out), .recovered_clock_oe_n(), .recovered_data_out(recovered_data_out),
    .recovered_data_oe_n(), .rate_error_flag(rate_error_flag),
    .rate_error_oe_n(), .pll_ready_n(pll_ready_n), .pll_ready_oe_n(pll_ready_oe_n)
  );
  rp_line_model osc_model_inst (.hclk(hclk), .gap(8'h4), .line(oscillator_input));
  rp_line_model rx_model_inst (.hclk(hclk), .gap(mute_rx ? 8'h0 : gap), .line(rcv_line));
  rp_line_model tx_model_inst (.hclk(hclk), .gap(mute_tx ? 8'h0 : gap), .line(drv_line));

  initial forever #2.5 hclk = ~hclk;

  function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Random legal spacing for the chosen speed; a held bad request gives 40
  always @(posedge hclk) begin
    seed <= xs(seed);
    gap  <= bad ? 8'h28 : ring_speed_select ? 8'h8 + {5'h0, seed[2:0]} : 8'h1e + {3'h0, seed[4:0]};
  end

  task test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  always @(posedge hclk) begin
    if (rd_ph) chk("hrdata", q_exp.pop_front(), hrdata & q_msk.pop_front());
    rd_ph <= hsel && htrans[1] && hreadyout && !hwrite;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus

  task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    q_exp.push_back(e & m);
    q_msk.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd

  function logic pin(input int k);
    case (k)
      0: return pll_ready_n;
      1: return rate_error_flag;
      2: return pll_ready_oe_n;
      3: return irq;
      4: return divided_clock_out;
      5: return recovered_clock_out;
      default: return recovered_data_out;
    endcase
  endfunction : pin

  task wait_pin(input int k, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && pin(k) !== v; i++) @(negedge hclk);
    chk($sformatf("pin%0d", k), {31'h0, v}, {31'h0, pin(k)});
  endtask : wait_pin

  // ------
  // Main sequence
  // ------
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`RP_OFF_INT_EN, 32'h0, 32'hffffffff);
    rd(12'h020, 32'h0, 32'hffffffff);
    rd(`RP_OFF_STATUS, 32'h2, 32'h2);
    bus(1'b1, `RP_OFF_INT_EN, 32'h7);
    rd(`RP_OFF_INT_EN, 32'h7, 32'hffffffff);
    wait_pin(0, 1'b0, 3000);
    repeat (700) @(posedge hclk);
    rd(`RP_OFF_STATUS, 32'hc, 32'hf);
    // Divided clock, recovered clock and recovered data must all keep moving
    for (int k = 4; k < 7; k++) begin
      wait_pin(k, 1'b1, 40);
      wait_pin(k, 1'b0, 40);
    end
    bus(1'b1, `RP_OFF_INT_CLR, 32'h7);
    bad <= 1'b1;
    wait_pin(1, 1'b1, 300);
    rd(`RP_OFF_INT_STAT, 32'h1, 32'h1);
    bus(1'b1, `RP_OFF_INT_EN, 32'h0);
    wait_pin(3, 1'b0, 4);
    bus(1'b1, `RP_OFF_INT_EN, 32'h7);
    wait_pin(3, 1'b1, 4);
    @(posedge hclk);
    bad <= 1'b0;
    wait_pin(1, 1'b0, 400);
    wait_pin(0, 1'b0, 3000);
    bus(1'b1, `RP_OFF_INT_CLR, 32'h7);
    rd(`RP_OFF_INT_STAT, 32'h0, 32'h7);
    wait_pin(3, 1'b0, 4);
    @(posedge hclk);
    freq_acquire_request <= 1'b1;
    repeat (6) @(posedge hclk);
    freq_acquire_request <= 1'b0;
    wait_pin(0, 1'b1, 4);
    rd(`RP_OFF_INT_STAT, 32'h2, 32'h2);
    wait_pin(0, 1'b0, 3000);
    rd(`RP_OFF_INT_STAT, 32'h4, 32'h4);
    bus(1'b1, `RP_OFF_CTRL, 32'h1);
    wait_pin(0, 1'b1, 8);
    rd(`RP_OFF_CTRL, 32'h0, 32'hffffffff);
    wait_pin(0, 1'b0, 3000);
    @(posedge hclk);
    ring_speed_select <= 1'b0;
    osc_divide_select <= 1'b1;
    wait_pin(0, 1'b1, 8);
    wait_pin(0, 1'b0, 3000);
    repeat (700) @(posedge hclk);
    rd(`RP_OFF_STATUS, 32'h8, 32'hf);
    @(posedge hclk);
    wrap_n  <= 1'b0;
    mute_rx <= 1'b1;
    repeat (400) @(posedge hclk);
    wait_pin(0, 1'b0, 3000);
    rd(`RP_OFF_STATUS, 32'h8, 32'hb);
    @(posedge hclk);
    mute_tx <= 1'b1;
    wait_pin(0, 1'b1, 300);
    rd(`RP_OFF_STATUS, 32'h2, 32'hb);
    @(posedge hclk);
    phy_power_down_n <= 1'b0;
    wait_pin(2, 1'b1, 8);
    repeat (8) @(posedge hclk);
    phy_power_down_n <= 1'b1;
    wait_pin(2, 1'b0, 8);
    repeat (40) @(posedge hclk);
    test_done();
  end
endmodule : ring_phy_clock_status_bench
